/* File: rtl/pracc_top.sv */
// Page-ROM access control: on/off-page decision and wait insertion for block 7.
// Assumes the bus controller core issues one access request at a time and
// drives the register port synchronously to mclk.
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps

// Contract
// - On-page accesses get 0 to 3 waits from config bits 2..1.
// - Page settings act only when block 7 selects the page-ROM cycle.
// - Off-page waits come from the block 7 wait setting.
// - Page size bit clear: 16-byte page, first burst access off-page.
// - Page size set on 16-bit bus: 8-byte page, accesses 1 and 5 off-page.
// - 32-bit bus ignores page size bit; only first of four off-page.
module pracc_top (
  input wire logic mclk, // bus clock, 250 MHz
  input wire logic resetn, // async reset, active low
  input wire logic [31:0] reg_addr, // register byte address
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [15:0] reg_rdata, // read data, cycle after reg_rd
  input wire logic acc_req, // access request pulse
  input wire logic acc_first, // request is first of a burst
  input wire logic [23:0] acc_addr, // access byte address
  output logic acc_busy, // access in progress
  output logic acc_offpage, // last access was off-page
  output logic [2:0] acc_waits, // waits applied to last access
  output logic acc_done // access end pulse
);

  logic [15:0] page_rom_config;
  logic [15:0] block7_ctrl;
  logic [15:0] next_page_rom_config;
  logic [15:0] next_block7_ctrl;
  logic [15:0] next_reg_rdata;

  pracc_pkg::pracc_state_t state;
  pracc_pkg::pracc_state_t next_state;
  logic [23:0] last_addr;
  logic [23:0] next_last_addr;
  logic next_acc_offpage;
  logic [2:0] next_acc_waits;
  logic next_acc_busy;

  logic page_mode;
  logic page8;
  logic same_page;
  logic [1:0] onpage_wait_count;
  logic [2:0] block7_wait_states;
  logic take;
  logic offpage_now;
  logic [2:0] waits_now;
  logic wg_done;

  // Register file
  always_comb begin
    next_page_rom_config = page_rom_config;
    next_block7_ctrl = block7_ctrl;
    next_reg_rdata = 16'h0000;
    if (reg_wr) begin
      if (reg_addr == pracc_pkg::PRACC_ADDR_PAGE_ROM_CONFIG) begin
        next_page_rom_config = reg_wdata & pracc_pkg::PRACC_PAGE_ROM_CONFIG_MASK;
      end
      if (reg_addr == pracc_pkg::PRACC_ADDR_BLOCK7_CTRL) begin
        next_block7_ctrl = reg_wdata & pracc_pkg::PRACC_BLOCK7_CTRL_MASK;
      end
    end
    if (reg_rd) begin
      unique case (reg_addr)
        pracc_pkg::PRACC_ADDR_PAGE_ROM_CONFIG: begin
          next_reg_rdata = page_rom_config;
        end
        pracc_pkg::PRACC_ADDR_BLOCK7_CTRL: begin
          next_reg_rdata = block7_ctrl;
        end
        pracc_pkg::PRACC_ADDR_ACCESS_STATUS: begin
          next_reg_rdata[pracc_pkg::PRACC_ST_BUSY_BIT] = acc_busy;
          next_reg_rdata[pracc_pkg::PRACC_ST_OFFPAGE_BIT] = acc_offpage;
          next_reg_rdata[pracc_pkg::PRACC_ST_PAGE8_BIT] = page8;
          next_reg_rdata[pracc_pkg::PRACC_ST_WAITS_LSB +: 3] = acc_waits;
        end
        default: begin
          next_reg_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      page_rom_config <= pracc_pkg::PRACC_PAGE_ROM_CONFIG_RESET;
      block7_ctrl <= pracc_pkg::PRACC_BLOCK7_CTRL_RESET;
      reg_rdata <= 16'h0000;
    end else begin
      page_rom_config <= next_page_rom_config;
      block7_ctrl <= next_block7_ctrl;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Field decode
  assign onpage_wait_count =
    page_rom_config[pracc_pkg::PRACC_PWS_MSB:pracc_pkg::PRACC_PWS_LSB];
  assign block7_wait_states =
    block7_ctrl[pracc_pkg::PRACC_WS7_MSB:pracc_pkg::PRACC_WS7_LSB];
  assign page_mode = block7_ctrl[pracc_pkg::PRACC_CT7_BIT];
  assign page8 = page_rom_config[pracc_pkg::PRACC_PS_BIT]
               & ~block7_ctrl[pracc_pkg::PRACC_BUS32_BIT];

  assign same_page = page8
    ? (acc_addr[23:pracc_pkg::PRACC_PAGE8_LSB] == last_addr[23:pracc_pkg::PRACC_PAGE8_LSB])
    : (acc_addr[23:pracc_pkg::PRACC_PAGE16_LSB] == last_addr[23:pracc_pkg::PRACC_PAGE16_LSB]);

  // Requests arriving while an access runs are ignored
  assign take = acc_req & (state == pracc_pkg::PRACC_IDLE);

  // Without page mode every access is a plain block 7 cycle
  // first access off-page
  assign offpage_now = ~page_mode | acc_first | ~same_page;

  assign waits_now = offpage_now ? block7_wait_states : {1'b0, onpage_wait_count};

  // Access sequencing
  always_comb begin
    next_state = state;
    next_last_addr = last_addr;
    next_acc_offpage = acc_offpage;
    next_acc_waits = acc_waits;
    unique case (state)
      pracc_pkg::PRACC_IDLE: begin
        if (take) begin
          next_state = pracc_pkg::PRACC_WAIT;
          next_last_addr = acc_addr;
          next_acc_offpage = offpage_now;
          next_acc_waits = waits_now;
        end
      end
      pracc_pkg::PRACC_WAIT: begin
        if (wg_done) begin
          next_state = pracc_pkg::PRACC_IDLE;
        end
      end
      default: begin
        next_state = pracc_pkg::PRACC_IDLE;
      end
    endcase
    next_acc_busy = (next_state == pracc_pkg::PRACC_WAIT);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= pracc_pkg::PRACC_IDLE;
      last_addr <= 24'h000000;
      acc_offpage <= 1'b0;
      acc_waits <= 3'h0;
      acc_busy <= 1'b0;
    end else begin
      state <= next_state;
      last_addr <= next_last_addr;
      acc_offpage <= next_acc_offpage;
      acc_waits <= next_acc_waits;
      acc_busy <= next_acc_busy;
    end
  end

  pracc_wait_gen u_wait (
    .mclk(mclk),
    .resetn(resetn),
    .load(take),
    .count(waits_now),
    .busy(),
    .done(wg_done)
  );

  assign acc_done = wg_done;

endmodule

/* File: inc/pracc_pkg.sv */
// Constants and types for the page-ROM access control block.
// Assumes a 32-bit byte address on the register port and 16-bit register data.
package pracc_pkg;

  // Register byte addresses
  localparam logic [31:0] PRACC_ADDR_PAGE_ROM_CONFIG = 32'hC0000024;
  localparam logic [31:0] PRACC_ADDR_BLOCK7_CTRL = 32'hC0000100;
  localparam logic [31:0] PRACC_ADDR_ACCESS_STATUS = 32'hC0000104;

  // page_rom_config fields
  localparam int PRACC_PS_BIT = 0;
  localparam int PRACC_PWS_LSB = 1;
  localparam int PRACC_PWS_MSB = 2;
  localparam logic [15:0] PRACC_PAGE_ROM_CONFIG_RESET = 16'h0006;
  localparam logic [15:0] PRACC_PAGE_ROM_CONFIG_MASK = 16'h0007;

  // block7_ctrl fields
  localparam int PRACC_CT7_BIT = 0;
  localparam int PRACC_WS7_LSB = 1;
  localparam int PRACC_WS7_MSB = 3;
  localparam int PRACC_BUS32_BIT = 4;
  localparam logic [15:0] PRACC_BLOCK7_CTRL_RESET = 16'h000E;
  localparam logic [15:0] PRACC_BLOCK7_CTRL_MASK = 16'h001F;

  // access_status fields
  localparam int PRACC_ST_BUSY_BIT = 0;
  localparam int PRACC_ST_OFFPAGE_BIT = 1;
  localparam int PRACC_ST_PAGE8_BIT = 2;
  localparam int PRACC_ST_WAITS_LSB = 4;

  // Page boundaries: 16-byte page uses address bit 4 up, 8-byte page bit 3 up
  localparam int PRACC_ADDR_W = 24;
  localparam int PRACC_PAGE16_LSB = 4;
  localparam int PRACC_PAGE8_LSB = 3;

  localparam int PRACC_WAIT_W = 3;
  localparam logic [PRACC_WAIT_W-1:0] PRACC_WAIT_ZERO = 3'h0;
  localparam logic [PRACC_WAIT_W-1:0] PRACC_WAIT_ONE = 3'h1;

  typedef enum logic [1:0] {
    PRACC_IDLE = 2'b01,
    PRACC_WAIT = 2'b10
  } pracc_state_t;

endpackage

/* File: rtl/pracc_wait_gen.sv */
// Wait-state counter for one bus access.
// Assumes load is a one-cycle pulse given only while not busy.
`timescale 1ns/100ps
module pracc_wait_gen (
  input wire logic mclk, // bus clock
  input wire logic resetn, // async reset, active low
  input wire logic load, // start counting
  input wire logic [pracc_pkg::PRACC_WAIT_W-1:0] count, // wait states
  output logic busy, // counting
  output logic done // one-cycle end pulse
);

  logic [pracc_pkg::PRACC_WAIT_W-1:0] cnt;
  logic [pracc_pkg::PRACC_WAIT_W-1:0] next_cnt;
  logic next_busy;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    if (load) begin
      next_cnt = count;
      next_busy = 1'b1;
    end else if (busy) begin
      if (cnt == pracc_pkg::PRACC_WAIT_ZERO) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end else begin
        next_cnt = cnt - pracc_pkg::PRACC_WAIT_ONE;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= pracc_pkg::PRACC_WAIT_ZERO;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule

/* File: dv/pracc_checker.sv */
// Port checker for the page-ROM access control block.
// Assumes registers change only through reg_wr.
`timescale 1ns/100ps
module pracc_checker (
  input wire logic mclk, // clock
  input wire logic resetn, // reset, active low
  input wire logic [31:0] reg_addr, // address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic acc_req, // request
  input wire logic acc_first, // burst start
  input wire logic [23:0] acc_addr, // access address
  input wire logic acc_busy, // busy
  input wire logic acc_offpage, // off-page
  input wire logic [2:0] acc_waits, // waits
  input wire logic acc_done // done
);
  logic [2:0] cfg, next_cfg;
  logic [4:0] b7, next_b7;
  logic [23:0] prev, next_prev;
  logic take, p8, off;
  always_comb begin
    take = acc_req && !acc_busy;
    p8 = cfg[0] && !b7[4];
    off = !b7[0] || acc_first || (p8 ? acc_addr[23:3] != prev[23:3]
                                     : acc_addr[23:4] != prev[23:4]);
    next_cfg = cfg;
    next_b7 = b7;
    next_prev = take ? acc_addr : prev;
    if (reg_wr && reg_addr == pracc_pkg::PRACC_ADDR_PAGE_ROM_CONFIG) next_cfg = reg_wdata[2:0];
    if (reg_wr && reg_addr == pracc_pkg::PRACC_ADDR_BLOCK7_CTRL) next_b7 = reg_wdata[4:0];
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg <= pracc_pkg::PRACC_PAGE_ROM_CONFIG_RESET[2:0];
      b7 <= pracc_pkg::PRACC_BLOCK7_CTRL_RESET[4:0];
      prev <= 24'h000000;
    end else begin
      cfg <= next_cfg;
      b7 <= next_b7;
      prev <= next_prev;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_onpage_waits: assert property (
    take && !off |=> acc_waits == {1'b0, $past(cfg[2:1])}) else $error("on-page waits wrong");
  a_done_bound: assert property (
    take |=> acc_busy ##[1:8] acc_done) else $error("access end late");
  a_mode_gate: assert property (
    take && !b7[0] |=> acc_offpage) else $error("page mode leaked");
  a_offpage_waits: assert property (
    take && off |=> acc_waits == $past(b7[3:1])) else $error("off-page waits wrong");
  a_first_off: assert property (
    take && acc_first |=> acc_offpage) else $error("first access on-page");
  a_page8_split: assert property (
    take && p8 && b7[0] |=> acc_offpage == $past(off)) else $error("8-byte page wrong");
  a_bus32_ignore: assert property (
    take && b7[4] && b7[0] && !acc_first && acc_addr[23:4] == prev[23:4] |=> !acc_offpage)
    else $error("32-bit page split");
  a_page_track: assert property (
    take && b7[0] |=> acc_offpage == $past(off)) else $error("page tracking wrong");
endmodule
bind pracc_top pracc_checker u_pracc_checker (.mclk(mclk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .acc_req(acc_req),
  .acc_first(acc_first), .acc_addr(acc_addr), .acc_busy(acc_busy),
  .acc_offpage(acc_offpage), .acc_waits(acc_waits), .acc_done(acc_done));

/* File: dv/pracc_burst_src.sv */
// Burst requester standing for the bus core in front of the page ROM.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/100ps
module pracc_burst_src (
  input wire logic mclk, // clock
  input wire logic start, // begin burst
  input wire logic [23:0] base, // first address
  input wire logic [3:0] beats, // accesses
  input wire logic [4:0] step, // address step
  input wire logic acc_done, // access end
  input wire logic acc_offpage, // off-page flag
  output logic acc_req, // request pulse
  output logic acc_first, // burst start
  output logic [23:0] acc_addr, // address
  output logic [7:0] offmap, // off-page per beat
  output logic idle // no burst running
);
  int i;
  initial begin
    acc_req = 1'b0;
    acc_first = 1'b0;
    acc_addr = 24'h000000;
    offmap = 8'h00;
    idle = 1'b1;
  end
  always begin
    @(posedge mclk);
    if (start) begin
      idle <= 1'b0;
      offmap <= 8'h00;
      for (i = 0; i < beats; i++) begin
        // first flag only on beat zero
        acc_req <= 1'b1;
        acc_first <= (i == 0);
        acc_addr <= base + 24'(i) * step;
        @(posedge mclk);
        acc_req <= 1'b0;
        // Next request only after the end pulse
        do @(posedge mclk); while (!acc_done);
        offmap[i] <= acc_offpage;
      end
      idle <= 1'b1;
    end
  end
endmodule

/* File: dv/pracc_top_test.sv */
// Self-checking bench for the page-ROM access control block.
// Assumes the burst requester model drives the access port.
`timescale 1ns/100ps
module pracc_top_test;
  localparam logic [31:0] CFG = pracc_pkg::PRACC_ADDR_PAGE_ROM_CONFIG;
  localparam logic [31:0] B7 = pracc_pkg::PRACC_ADDR_BLOCK7_CTRL;
  logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, start = 0;
  logic [31:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata;
  logic [23:0] base = 0, acc_addr;
  logic [3:0] beats = 0;
  logic [4:0] step = 0;
  logic acc_req, acc_first, acc_busy, acc_offpage, acc_done, idle;
  logic [2:0] acc_waits;
  logic [7:0] offmap;
  int errors = 0, compares = 0;
  always #2 mclk = ~mclk;
  pracc_top u_pracc_top (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_req(acc_req), .acc_first(acc_first), .acc_addr(acc_addr), .acc_busy(acc_busy),
    .acc_offpage(acc_offpage), .acc_waits(acc_waits), .acc_done(acc_done));
  pracc_burst_src u_pracc_burst_src (.mclk(mclk), .start(start), .base(base),
    .beats(beats), .step(step), .acc_done(acc_done), .acc_offpage(acc_offpage),
    .acc_req(acc_req), .acc_first(acc_first), .acc_addr(acc_addr), .offmap(offmap),
    .idle(idle));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rdc(input logic [31:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
  endtask
  // Runs one burst, then compares off-page map and last waits
  task burst(input logic [23:0] b, input logic [3:0] n, input logic [4:0] s,
             input logic [7:0] m, input logic [2:0] w);
    int k;
    @(posedge mclk);
    base <= b;
    beats <= n;
    step <= s;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (k = 0; k < 300; k++) begin
      @(posedge mclk);
      if (idle) break;
    end
    // A burst that never ends is a mismatch
    if (!idle) errors++;
    check({8'h00, offmap}, {8'h00, m});
    check({13'h0000, acc_waits}, {13'h0000, w});
  endtask
  task wrap_up;
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    int c;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    rdc(CFG, 16'h0006);
    rdc(B7, 16'h000E);
    rdc(32'hC0000028, 16'h0000);
    burst(24'h000000, 4, 2, 8'h0F, 3'h7);
    wr(B7, 16'h000B);
    wr(CFG, 16'h0003);
    rdc(B7, 16'h000B);
    rdc(CFG, 16'h0003);
    burst(24'h000000, 8, 2, 8'h11, 3'h1);
    rdc(pracc_pkg::PRACC_ADDR_ACCESS_STATUS, 16'h0014);
    burst(24'h000010, 1, 2, 8'h01, 3'h5);
    rdc(pracc_pkg::PRACC_ADDR_ACCESS_STATUS, 16'h0056);
    wr(CFG, 16'h0002);
    burst(24'h000008, 8, 2, 8'h11, 3'h1);
    burst(24'h000020, 8, 2, 8'h01, 3'h1);
    wr(B7, 16'h001B);
    wr(CFG, 16'h0001);
    burst(24'h000000, 4, 4, 8'h01, 3'h0);
    for (c = 0; c < 4; c++) begin
      wr(CFG, 16'(c * 2));
      burst(24'h000040, 2, 4, 8'h01, 3'(c));
    end
    wrap_up;
  end
  initial begin
    #60000;
    errors++;
    wrap_up;
  end
endmodule
